// ===== design/serial_rx_error_flags.sv
// Purpose: serial receiver status flags with read-sequence clearing
// Assumes: Avalon-MM slave, 32-bit data, byte offsets on word boundaries, rxd synchronous
// Notes: flag clear is status read then data read, as in classic uarts
//
// Functional notes
// - noise on the receive input during a frame sets the noise flag, status bit 2
// - noise flag rises with data-full flag, never on an overrunning frame
// - status read then data read clears the noise flag
// - a zero sampled at the stop bit sets framing error, status bit 1
// - framing error rises with data-full flag, never on an overrunning frame
// - framing error set blocks reception of further frames until cleared
// - framing error clears after status read with it set, then data read
// - parity enabled and parity mismatch sets the parity error flag, status bit 0
// - parity error rises with data-full flag, never on an overrunning frame
// - status read then data read clears the parity error flag
// - completed frame moving into data register sets the data-full flag
// - frame ending while the data-full flag is set, except in the clearing data read cycle, sets overrun and discards the new frame
//
// Register access over Avalon-MM and the register offsets were left to the implementer.
`timescale 1ns/10ps
`default_nettype none
module serial_rx_error_flags
    import rx_err_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rstn,
    input wire logic [rx_err_pkg::ADDR_W-1:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    input wire logic rxd,
    output logic irq
);
    import rx_err_pkg::*;

    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    typedef struct packed {
        logic [2:0] ctrl;
        logic [BAUD_W-1:0] baud;
        logic rx_data_full_flag;
        logic ovr;
        logic nf;
        logic fe;
        logic pf;
        logic idle;
        logic idle_armed;
        logic [DATA_BITS-1:0] data;
        logic armed;
        logic [EV_W-1:0] pend;
        logic [EV_W-1:0] mask;
        logic ack;
        logic [31:0] rdata;
    } st_s;
    st_s st_r;
    st_s st_nxt;

    logic tick;
    logic line_idle;
    rx_frame_s frame;
    sw_access_s acc;

    rx_sampler u_sampler (
        .clk_sys(clk_sys),
        .rstn(rstn),
        .divisor(st_r.baud),
        .tick(tick)
    );

    rx_shifter u_shifter (
        .clk_sys(clk_sys),
        .rstn(rstn),
        .tick(tick),
        .rxd(rxd),
        // a low stop bit keeps the line low; block starts before fe is registered
        .enable(st_r.ctrl[CT_RE] & ~st_r.fe & ~(frame.valid & frame.frame_err)),
        .parity_enable(st_r.ctrl[CT_PE]),
        .parity_type(st_r.ctrl[CT_PT]),
        .frame_out(frame),
        .line_idle(line_idle)
    );

    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
                                          input logic [3:0] be);
        logic [31:0] m;
        m = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
        merge = (old & ~m) | (wd & m);
    endfunction

    function automatic logic [7:0] status_byte(input st_s s);
        status_byte = '0;
        status_byte[ST_RX_DATA_FULL_FLAG] = s.rx_data_full_flag;
        status_byte[ST_IDLE] = s.idle;
        status_byte[ST_OR] = s.ovr;
        status_byte[ST_NF] = s.nf;
        status_byte[ST_FE] = s.fe;
        status_byte[ST_PF] = s.pf;
    endfunction

    // ----------------------------------------------------------------
    // next state
    // ----------------------------------------------------------------
    logic req;
    logic [31:0] wmerged;
    logic [EV_W-1:0] ev;
    logic clear_seq;
    always_comb
    begin
        st_nxt = st_r;
        req = (avs_read | avs_write) & ~st_r.ack;
        acc.rd_status = req & avs_read & ({1'b0, avs_address} == {2'b00, OFF_STATUS});
        acc.rd_data = req & avs_read & ({1'b0, avs_address} == {2'b00, OFF_DATA});
        st_nxt.ack = req;
        wmerged = '0;
        ev = '0;
        clear_seq = acc.rd_data & st_r.armed;
        // one wait cycle per access; answer registered
        if (req && avs_read)
        begin
            st_nxt.rdata = '0;
            if (avs_address == ADDR_W'(OFF_CTRL))
                st_nxt.rdata = {29'h0, st_r.ctrl};
            else if (avs_address == ADDR_W'(OFF_BAUD))
                st_nxt.rdata = {16'h0, st_r.baud};
            else if (avs_address == ADDR_W'(OFF_STATUS))
                st_nxt.rdata = {24'h0, status_byte(st_r)};
            else if (avs_address == ADDR_W'(OFF_DATA))
                st_nxt.rdata = {24'h0, st_r.data};
            else if (avs_address == OFF_IRQ_PEND)
                st_nxt.rdata = {29'h0, st_r.pend};
            else if (avs_address == OFF_IRQ_MASK)
                st_nxt.rdata = {29'h0, st_r.mask};
        end
        // status read arms the clear only if a flag is showing
        if (acc.rd_status && (status_byte(st_r) != 8'h00))
            st_nxt.armed = 1'b1;
        if (clear_seq)
        begin
            st_nxt.armed = 1'b0;
            st_nxt.rx_data_full_flag = 1'b0;
            st_nxt.ovr = 1'b0;
            st_nxt.idle = 1'b0;
            st_nxt.nf = 1'b0;
            st_nxt.fe = 1'b0;
            st_nxt.pf = 1'b0;
        end
        if (req && avs_write)
        begin
            if (avs_address == ADDR_W'(OFF_CTRL))
                st_nxt.ctrl = 3'(merge({29'h0, st_r.ctrl}, avs_writedata, avs_byteenable));
            else if (avs_address == ADDR_W'(OFF_BAUD))
                st_nxt.baud = 16'(merge({16'h0, st_r.baud}, avs_writedata, avs_byteenable));
            else if (avs_address == OFF_IRQ_MASK)
                st_nxt.mask = 3'(merge({29'h0, st_r.mask}, avs_writedata, avs_byteenable));
            else if (avs_address == OFF_IRQ_PEND)
            begin
                wmerged = merge(32'h0, avs_writedata, avs_byteenable);
                st_nxt.pend = st_r.pend & ~wmerged[EV_W-1:0];
            end
        end
        // a frame landing in the clear cycle sees the register as free
        if (frame.valid)
        begin
            if (st_r.rx_data_full_flag && !clear_seq)
            begin
                st_nxt.ovr = 1'b1;
                ev[EV_OR] = 1'b1;
            end
            else
            begin
                st_nxt.rx_data_full_flag = 1'b1;
                st_nxt.data = frame.data;
                st_nxt.nf = frame.noise;
                st_nxt.fe = frame.frame_err;
                st_nxt.pf = frame.par_err;
                st_nxt.idle_armed = 1'b1;
                ev[EV_RX] = 1'b1;
                ev[EV_ERR] = frame.noise | frame.frame_err | frame.par_err;
            end
        end
        if (line_idle && st_r.idle_armed && !frame.valid)
        begin
            st_nxt.idle = 1'b1;
            st_nxt.idle_armed = 1'b0;
        end
        // set beats the write-one clear
        st_nxt.pend = st_nxt.pend | ev;
    end

    // ----------------------------------------------------------------
    // registers
    // ----------------------------------------------------------------
    always_ff @(posedge clk_sys or negedge rstn)
    begin
        if (!rstn)
        begin
            st_r <= '0;
            st_r.ctrl <= CTRL_RST;
            st_r.baud <= BAUD_RST;
        end
        else
        begin
            st_r <= st_nxt;
        end
    end

    assign avs_waitrequest = (avs_read | avs_write) & ~st_r.ack;
    assign avs_readdata = st_r.rdata;
    assign irq = |(st_r.pend & st_r.mask);
endmodule
`default_nettype wire

// ===== inc/rx_err_pkg.sv
// Purpose: shared constants and types for the serial receive error flag block
// Assumes: 40 MHz system clock, Avalon-MM register slave with 32-bit data
// Notes: register offsets are byte addresses on word boundaries
package rx_err_pkg;

// ----------------------------------------------------------------
// register map
// ----------------------------------------------------------------
localparam logic [3:0] OFF_CTRL = 4'h0;
localparam logic [3:0] OFF_BAUD = 4'h4;
localparam logic [3:0] OFF_STATUS = 4'h8;
localparam logic [3:0] OFF_DATA = 4'hc;
localparam logic [3:0] OFF_IRQ_STAT = 4'h0;
localparam int ADDR_W = 5;
localparam logic [4:0] OFF_IRQ_PEND = 5'h10;
localparam logic [4:0] OFF_IRQ_MASK = 5'h14;

// status bit positions
localparam int ST_PF = 0;
localparam int ST_FE = 1;
localparam int ST_NF = 2;
localparam int ST_OR = 3;
localparam int ST_IDLE = 4;
localparam int ST_RX_DATA_FULL_FLAG = 5;

// control bit positions
localparam int CT_PT = 0;
localparam int CT_PE = 1;
localparam int CT_RE = 2;

// interrupt event positions
localparam int EV_RX = 0;
localparam int EV_ERR = 1;
localparam int EV_OR = 2;
localparam int EV_W = 3;

// ----------------------------------------------------------------
// timing and reset values
// ----------------------------------------------------------------
localparam int OVS = 16;
localparam int OVS_W = 4;
localparam int VOTE_A = 7;
localparam int VOTE_B = 8;
localparam int VOTE_C = 9;
localparam int DATA_BITS = 8;
localparam int BAUD_W = 16;
localparam logic [15:0] BAUD_RST = 16'h0010;
localparam logic [2:0] CTRL_RST = 3'h4;

typedef struct packed {
    logic valid;
    logic [DATA_BITS-1:0] data;
    logic noise;
    logic frame_err;
    logic par_err;
} rx_frame_s;

typedef struct packed {
    logic rd_status;
    logic rd_data;
} sw_access_s;

endpackage

// ===== design/rx_sampler.sv
// Purpose: 16x oversampling tick generator
// Assumes: divisor of zero is treated as one
// Notes: tick is high one cycle in every divisor cycles, so it stays high for divisor 0 or 1
`timescale 1ns/10ps
`default_nettype none
module rx_sampler
    import rx_err_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rstn,
    input wire logic [BAUD_W-1:0] divisor,
    output logic tick
);
    typedef struct packed {
        logic [BAUD_W-1:0] cnt;
        logic tick;
    } st_s;
    st_s st_r;
    st_s st_nxt;

    always_comb
    begin
        st_nxt = st_r;
        st_nxt.tick = 1'b0;
        if (st_r.cnt + 16'h0001 >= divisor)
        begin
            st_nxt.cnt = '0;
            st_nxt.tick = 1'b1;
        end
        else
        begin
            st_nxt.cnt = st_r.cnt + 16'h0001;
        end
    end

    always_ff @(posedge clk_sys or negedge rstn)
    begin
        if (!rstn)
            st_r <= '0;
        else
            st_r <= st_nxt;
    end

    assign tick = st_r.tick;
endmodule
`default_nettype wire

// ===== design/rx_shifter.sv
// Purpose: frame receiver with majority voting and noise detect
// Assumes: 8 data bits, optional parity bit, one stop bit
// Notes: frame_out.valid pulses for one cycle, one tick after the last stop bit sample
`timescale 1ns/10ps
`default_nettype none
module rx_shifter
    import rx_err_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rstn,
    input wire logic tick,
    input wire logic rxd,
    input wire logic enable,
    input wire logic parity_enable,
    input wire logic parity_type,
    output rx_err_pkg::rx_frame_s frame_out,
    output logic line_idle
);
    import rx_err_pkg::*;

    typedef enum logic [2:0] {S_IDLE, S_START, S_DATA, S_PAR, S_STOP} ph_e;

    typedef struct packed {
        ph_e ph;
        logic [OVS_W-1:0] sub;
        logic [3:0] bitn;
        logic [2:0] votes;
        logic [DATA_BITS-1:0] shreg;
        logic noisy;
        logic par;
        logic par_bad;
        rx_frame_s frame;
    } st_s;
    st_s st_r;
    st_s st_nxt;

    // majority of three samples; any disagreement marks noise
    function automatic logic majority(input logic [2:0] v);
        majority = (v[0] & v[1]) | (v[1] & v[2]) | (v[0] & v[2]);
    endfunction

    function automatic logic disagree(input logic [2:0] v);
        disagree = (v != 3'b000) && (v != 3'b111);
    endfunction

    logic bitval;
    logic last_sub;
    always_comb
    begin
        bitval = majority(st_r.votes);
        last_sub = (st_r.sub == OVS_W'(OVS-1));
        st_nxt = st_r;
        st_nxt.frame.valid = 1'b0;
        if (tick && st_r.ph != S_IDLE)
        begin
            st_nxt.sub = st_r.sub + 1'b1;
            if (st_r.sub == OVS_W'(VOTE_A))
                st_nxt.votes[0] = rxd;
            if (st_r.sub == OVS_W'(VOTE_B))
                st_nxt.votes[1] = rxd;
            if (st_r.sub == OVS_W'(VOTE_C))
                st_nxt.votes[2] = rxd;
        end
        unique case (st_r.ph)
            S_IDLE:
            begin
                if (tick && enable && !rxd)
                begin
                    st_nxt.ph = S_START;
                    st_nxt.sub = OVS_W'(1);
                    st_nxt.noisy = 1'b0;
                    st_nxt.par = parity_type;
                    st_nxt.bitn = '0;
                end
            end
            S_START:
            begin
                if (tick && last_sub)
                begin
                    st_nxt.noisy = disagree(st_r.votes);
                    st_nxt.ph = bitval ? S_IDLE : S_DATA;
                end
            end
            S_DATA:
            begin
                if (tick && last_sub)
                begin
                    st_nxt.noisy = st_r.noisy | disagree(st_r.votes);
                    st_nxt.shreg = {bitval, st_r.shreg[DATA_BITS-1:1]};
                    st_nxt.par = st_r.par ^ bitval;
                    st_nxt.bitn = st_r.bitn + 4'h1;
                    if (st_r.bitn == 4'(DATA_BITS-1))
                        st_nxt.ph = parity_enable ? S_PAR : S_STOP;
                end
            end
            S_PAR:
            begin
                if (tick && last_sub)
                begin
                    st_nxt.noisy = st_r.noisy | disagree(st_r.votes);
                    st_nxt.par_bad = st_r.par ^ bitval;
                    st_nxt.ph = S_STOP;
                end
            end
            S_STOP:
            begin
                if (tick && st_r.sub == OVS_W'(VOTE_C + 1))
                begin
                    st_nxt.ph = S_IDLE;
                    st_nxt.frame.valid = 1'b1;
                    st_nxt.frame.data = st_r.shreg;
                    st_nxt.frame.noise = st_r.noisy | disagree(st_r.votes);
                    st_nxt.frame.frame_err = !bitval;
                    st_nxt.frame.par_err = parity_enable & st_r.par_bad;
                    st_nxt.par_bad = 1'b0;
                end
            end
        endcase
    end

    always_ff @(posedge clk_sys or negedge rstn)
    begin
        if (!rstn)
            st_r <= '0;
        else
            st_r <= st_nxt;
    end

    assign frame_out = st_r.frame;
    assign line_idle = (st_r.ph == S_IDLE);
endmodule
`default_nettype wire

// ===== dv/serial_rx_error_flags_chk.sv
// Purpose: port-level checks for the receive error flag block
// Assumes: one clock, bus master holds each request until waitrequest low
// Notes: flag relations are only visible through completed status reads
`timescale 1ns/10ps
`default_nettype none
module serial_rx_error_flags_chk
    import rx_err_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rstn,
    input wire logic [rx_err_pkg::ADDR_W-1:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    input wire logic [31:0] avs_readdata,
    input wire logic avs_waitrequest,
    input wire logic rxd,
    input wire logic irq
);
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!rstn);
    // ----
    // bus completion steps
    // ----
    sequence s_rd(logic [4:0] a);
        avs_read && !avs_waitrequest && avs_address == a;
    endsequence
    sequence s_wr(logic [4:0] a);
        avs_write && !avs_waitrequest && avs_address == a;
    endsequence
    property p_wait_first; $rose(avs_read || avs_write) |-> avs_waitrequest; endproperty
    property p_wait_one; (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest; endproperty
    property p_no_wait; !(avs_read || avs_write) |-> !avs_waitrequest; endproperty
    property p_unmapped; s_rd(5'h18) |-> avs_readdata == 32'h0; endproperty
    property p_status_pad; s_rd(OFF_STATUS) |-> avs_readdata[31:6] == 26'h0; endproperty
    property p_data_pad; s_rd(OFF_DATA) |-> avs_readdata[31:8] == 24'h0; endproperty
    property p_err_full; s_rd(OFF_STATUS) ##0 (|avs_readdata[2:0]) |-> avs_readdata[ST_RX_DATA_FULL_FLAG];
    endproperty
    property p_mask_off; s_wr(OFF_IRQ_MASK) ##0 (avs_writedata[2:0] == 3'h0) |-> ##[1:2] !irq;
    endproperty
    // readdata only moves at the edge that ends a read's wait cycle
    property p_rd_stand; !(avs_read && avs_waitrequest) |=> $stable(avs_readdata); endproperty
    a_wait_first: assert property (p_wait_first) else $error("waitrequest low on new request");
    a_wait_one: assert property (p_wait_one) else $error("more than one wait cycle");
    a_no_wait: assert property (p_no_wait) else $error("waitrequest high while idle");
    a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
    a_status_pad: assert property (p_status_pad) else $error("status upper bits set");
    a_data_pad: assert property (p_data_pad) else $error("data upper bits set");
    a_err_full: assert property (p_err_full) else $error("error flag without data full");
    a_mask_off: assert property (p_mask_off) else $error("irq high with all masked");
    a_rd_stand: assert property (p_rd_stand) else $error("readdata moved without read");
endmodule
bind serial_rx_error_flags serial_rx_error_flags_chk chk_inst (.clk_sys(clk_sys), .rstn(rstn),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .rxd(rxd), .irq(irq));
`default_nettype wire

// ===== dv/serial_tx_model.sv
// Purpose: remote serial transmitter driving the receive line
// Assumes: divisor 1, so one bit is 16 clocks
// Notes: noise is a one-clock glitch on the middle vote of data bit 3, data survives
`timescale 1ns/10ps
`default_nettype none
module serial_tx_model
(
    input wire logic clk_sys,
    output logic rxd
);
    initial rxd = 1'b1;
    task automatic send(input logic [7:0] d, input logic use_par, input logic par,
        input logic stop_v, input logic noisy);
        logic [10:0] bits;
        int n;
        bits = {stop_v, par, d, 1'b0};
        n = use_par ? 11 : 10;
        if (!use_par)
            bits[9] = stop_v;
        for (int i = 0; i < n; i++)
            for (int k = 0; k < 16; k++)
            begin
                @(posedge clk_sys);
                rxd <= (noisy && i == 4 && k == 8) ? !bits[i] : bits[i];
            end
        @(posedge clk_sys);
        rxd <= 1'b1;
    endtask
endmodule
`default_nettype wire

// ===== dv/serial_rx_error_flags_tb.sv
// Purpose: self-checking bench for the receive error flag block
// Assumes: 40 MHz clock, divisor set to 1 after reset
// Notes: flags are judged only through bus reads, idle bit masked out
`timescale 1ns/10ps
`default_nettype none
module serial_rx_error_flags_tb;
    import rx_err_pkg::*;
    localparam logic [31:0] FM = 32'h2f;
    logic clk_sys = 1'b0;
    logic rstn = 1'b0;
    logic [ADDR_W-1:0] avs_address = '0;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [31:0] avs_writedata = '0;
    logic [31:0] avs_readdata;
    logic avs_waitrequest;
    logic rxd;
    logic irq;
    int bad_count = 0;
    int compares = 0;
    always #12.5 clk_sys = ~clk_sys;
    serial_rx_error_flags serial_rx_error_flags_inst (.clk_sys(clk_sys), .rstn(rstn),
        .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_byteenable(4'hf), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .rxd(rxd), .irq(irq));
    serial_tx_model serial_tx_model_inst (.clk_sys(clk_sys), .rxd(rxd));
    // ----
    // shared tasks
    // ----
    task automatic give_verdict();
        if (bad_count == 0 && compares > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    task automatic check_word(input string what, input logic [31:0] exp, input logic [31:0] got);
        compares++;
        if (got !== exp)
        begin
            bad_count++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask
    // request held until the rising edge that samples waitrequest low; released right there
    task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] wd,
        output logic [31:0] rd);
        int n;
        @(posedge clk_sys);
        avs_address <= a;
        avs_write <= wr;
        avs_read <= !wr;
        avs_writedata <= wd;
        n = 0;
        do
        begin
            @(posedge clk_sys);
            n++;
        end
        while (avs_waitrequest !== 1'b0 && n < 40);
        if (avs_waitrequest !== 1'b0)
        begin
            bad_count++;
            give_verdict();
        end
        rd = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask
    task automatic wr(input logic [4:0] a, input logic [31:0] wd);
        logic [31:0] v;
        bus(1'b1, a, wd, v);
    endtask
    task automatic rd_chk(input logic [4:0] a, input logic [31:0] m, input logic [31:0] e,
        input string what);
        logic [31:0] v;
        bus(1'b0, a, 32'h0, v);
        check_word(what, e, v & m);
    endtask
    // ----
    // scenarios
    // ----
    task automatic t_reset();
        rd_chk(OFF_STATUS, 32'hffffffff, 32'h0, "status at reset");
        rd_chk(OFF_CTRL, 32'h7, 32'h4, "ctrl at reset");
        rd_chk(OFF_BAUD, 32'hffff, 32'h10, "baud at reset");
        rd_chk(5'h18, 32'hffffffff, 32'h0, "unmapped");
        wr(OFF_BAUD, 32'h1);
    endtask
    task automatic t_clean();
        wr(OFF_IRQ_MASK, 32'h1);
        serial_tx_model_inst.send(8'ha5, 1'b0, 1'b0, 1'b1, 1'b0);
        @(negedge clk_sys);
        check_word("irq raised", 32'h1, {31'h0, irq});
        rd_chk(OFF_STATUS, FM, 32'h20, "clean status");
        rd_chk(OFF_DATA, 32'hff, 32'ha5, "clean data");
        rd_chk(OFF_STATUS, FM, 32'h0, "clean cleared");
        rd_chk(OFF_IRQ_PEND, 32'h1, 32'h1, "rx pending");
        wr(OFF_IRQ_PEND, 32'h1);
        @(negedge clk_sys);
        check_word("irq cleared", 32'h0, {31'h0, irq});
        wr(OFF_IRQ_MASK, 32'h0);
    endtask
    task automatic t_noise();
        logic [31:0] v;
        serial_tx_model_inst.send(8'h5a, 1'b0, 1'b0, 1'b1, 1'b1);
        bus(1'b0, OFF_DATA, 32'h0, v);
        rd_chk(OFF_STATUS, FM, 32'h24, "noise kept");
        rd_chk(OFF_DATA, 32'hff, 32'h5a, "noise data");
        rd_chk(OFF_STATUS, FM, 32'h0, "noise cleared");
    endtask
    task automatic t_frame();
        serial_tx_model_inst.send(8'h81, 1'b0, 1'b0, 1'b0, 1'b0);
        serial_tx_model_inst.send(8'h3c, 1'b0, 1'b0, 1'b1, 1'b0);
        rd_chk(OFF_STATUS, FM, 32'h22, "framing blocks");
        rd_chk(OFF_DATA, 32'hff, 32'h81, "framing data");
        rd_chk(OFF_STATUS, FM, 32'h0, "framing cleared");
        serial_tx_model_inst.send(8'h66, 1'b0, 1'b0, 1'b1, 1'b0);
        rd_chk(OFF_STATUS, FM, 32'h20, "reception resumed");
        rd_chk(OFF_DATA, 32'hff, 32'h66, "resumed data");
    endtask
    // both parity types, right and wrong parity bit
    task automatic t_parity();
        logic good;
        for (int t = 0; t < 2; t++)
            for (int b = 0; b < 2; b++)
            begin
                wr(OFF_CTRL, 32'h6 | t);
                good = t[0] ? ~^8'h37 : ^8'h37;
                serial_tx_model_inst.send(8'h37, 1'b1, good ^ b[0], 1'b1, 1'b0);
                rd_chk(OFF_STATUS, FM, 32'h20 | b, "parity status");
                rd_chk(OFF_DATA, 32'hff, 32'h37, "parity data");
                rd_chk(OFF_STATUS, FM, 32'h0, "parity cleared");
            end
    endtask
    // overrunning frame carries every error, none may show
    task automatic t_overrun();
        wr(OFF_CTRL, 32'h6);
        serial_tx_model_inst.send(8'h11, 1'b1, ^8'h11, 1'b1, 1'b0);
        serial_tx_model_inst.send(8'h22, 1'b1, ~^8'h22, 1'b0, 1'b1);
        rd_chk(OFF_STATUS, FM, 32'h28, "overrun status");
        rd_chk(OFF_DATA, 32'hff, 32'h11, "older data kept");
        rd_chk(OFF_STATUS, FM, 32'h0, "overrun cleared");
        wr(OFF_CTRL, 32'h4);
    endtask
    initial
    begin
        repeat (12) @(posedge clk_sys);
        rstn <= 1'b1;
        t_reset();
        t_clean();
        t_noise();
        t_frame();
        t_parity();
        t_overrun();
        give_verdict();
    end
endmodule
`default_nettype wire
